// ===== hdl/dsc_core.sv
`timescale 1ns/100ps
`default_nettype none
module dsc_core import dsc_pkg::*; #(
	parameter int DQ_W = 8,
	parameter int ROW_W = (DQ_W == 16) ? ROW_W_X16 : ROW_W_X8,
	parameter int ROW_KEEP = 2,
	parameter int CL = CL_DEF,
	parameter int CWL = CWL_DEF
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clk_link,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [BANK_W-1:0] ba,
	input wire logic [ROW_W-1:0] a,
	input wire logic [2*DQ_W-1:0] dq_i,
	input wire logic dqs_rise_i,
	input wire logic [1:0] dm_i,
	output logic [2*DQ_W-1:0] dq_o,
	output logic dq_oe_n,
	output logic [1:0] dqs_o,
	output logic dqs_oe_n,
	output logic tdqs_o,
	input wire logic [1:0] burst_mode,
	input wire logic burst_interleave,
	input wire logic tdqs_en,
	input wire logic dll_en,
	output logic [BANKS-1:0] bank_open,
	output logic [2:0] power_state,
	output logic illegal_cmd
);

	localparam int MEM_AW = BANK_W + ROW_KEEP + COL_W - 3;
	localparam int SYNC_W = 1 + BANKS + 3;

	typedef struct packed {
		dsc_power_type pwr;
		dsc_phase_type ph;
		logic [BANKS-1:0] open;
		logic [BANKS-1:0][ROW_W-1:0] row;
		logic [7:0] cnt;
		logic [1:0] beat;
		logic [1:0] last;
		logic [COL_W-1:0] col;
		logic [BANK_W-1:0] bank;
		logic ap;
		logic [PREFETCH*DQ_W-1:0] line;
		logic [PREFETCH-1:0] wbe;
		logic wr_go;
		logic [2*DQ_W-1:0] dq;
		logic dq_oe_n;
		logic [1:0] dqs;
		logic dqs_oe_n;
		logic tdqs;
		logic ill_tgl;
	} dsc_link_type;

	typedef struct packed {
		logic [BANKS-1:0] open;
		logic [2:0] pwr;
		logic tgl;
		logic ill;
	} dsc_sys_type;

	dsc_link_type c_q;
	dsc_link_type c_d;
	dsc_sys_type s_q;
	dsc_sys_type s_d;

	logic [4:0] cfg;
	logic [1:0] cfg_bm;
	logic cfg_il;
	logic cfg_tdqs;
	logic cfg_dll;
	logic [SYNC_W-1:0] stat;
	logic [2:0] cmd;
	logic [2:0] bi;
	logic chop;
	logic ill;
	logic rd_ok;
	logic wr_pair;
	logic m_rd;
	logic [MEM_AW-1:0] m_raddr;
	logic [MEM_AW-1:0] m_waddr;
	logic [PREFETCH*DQ_W-1:0] m_rdata;

	function automatic logic [MEM_AW-1:0] mk_addr(
		input logic [BANK_W-1:0] b, input logic [ROW_W-1:0] r,
		input logic [COL_W-1:0] c);
		return {b, r[ROW_KEEP-1:0], c[COL_W-1:3]};
	endfunction : mk_addr

	// ---------------------------------------------------------------
	// Clock domain crossings
	// ---------------------------------------------------------------
	dsc_sync3 #(.W(5)) u_cfg_sync (
		.clk(clk_link),
		.resetn(resetn),
		.d({burst_mode, burst_interleave, tdqs_en, dll_en}),
		.q(cfg)
	);

	assign cfg_bm = cfg[4:3];
	assign cfg_il = cfg[2];
	assign cfg_tdqs = cfg[1];
	assign cfg_dll = cfg[0];

	dsc_sync3 #(.W(SYNC_W)) u_stat_sync (
		.clk(clk_sys),
		.resetn(resetn),
		.d({c_q.ill_tgl, c_q.open, c_q.pwr}),
		.q(stat)
	);

	// ---------------------------------------------------------------
	// Array
	// ---------------------------------------------------------------
	assign m_waddr = mk_addr(c_q.bank, c_q.row[c_q.bank], c_q.col);

	dsc_mem #(.AW(MEM_AW), .DW(DQ_W)) u_mem (
		.clk(clk_link),
		.rd(m_rd),
		.raddr(m_raddr),
		.rdata_q(m_rdata),
		.we(c_q.wr_go),
		.waddr(m_waddr),
		.wdata(c_q.line),
		.wbe(c_q.wbe)
	);

	// ---------------------------------------------------------------
	// Link side: command decode, bursts, bank state
	// ---------------------------------------------------------------
	always_comb begin
		c_d = c_q;
		m_rd = 1'b0;
		m_raddr = '0;
		ill = 1'b0;
		rd_ok = 1'b0;
		wr_pair = 1'b0;
		bi = '0;
		cmd = {ras_n, cas_n, we_n};
		chop = (cfg_bm == BM_FIX4) || (cfg_bm == BM_OTF && !a[PIN_BC]);
		c_d.dq_oe_n = 1'b1;
		c_d.dqs_oe_n = 1'b1;
		c_d.dqs = DQS_PRE;
		c_d.wr_go = 1'b0;
		c_d.tdqs = cfg_tdqs;
		if (c_q.cnt != 8'hff)
			c_d.cnt = c_q.cnt + 8'h01;
		case (c_q.ph)
			PH_RLAT: begin
				if (c_q.cnt == 8'h01)
					c_d.line = m_rdata;
				if (c_q.cnt == 8'(CL - 1)) begin
					c_d.dqs_oe_n = 1'b0;
					c_d.ph = PH_RDAT;
					c_d.beat = '0;
				end
			end
			PH_RDAT: begin
				c_d.dq_oe_n = 1'b0;
				c_d.dqs_oe_n = 1'b0;
				c_d.dqs = DQS_BEAT;
				for (int j = 0; j < 2; j++) begin
					bi = beat_pos(c_q.col[2:0], {c_q.beat, j[0]}, cfg_il);
					c_d.dq[j*DQ_W +: DQ_W] = c_q.line[bi*DQ_W +: DQ_W];
				end
				c_d.beat = c_q.beat + 2'h1;
				if (c_q.beat == c_q.last) begin
					c_d.ph = PH_IDLE;
					if (c_q.ap)
						c_d.open[c_q.bank] = 1'b0;
				end
			end
			PH_WLAT: begin
				if (c_q.cnt >= 8'(CWL) && dqs_rise_i) begin
					wr_pair = 1'b1;
					c_d.ph = PH_WDAT;
				end else if (c_q.cnt > 8'(CWL + WR_SLACK)) begin
					ill = 1'b1;
					c_d.ph = PH_IDLE;
				end
			end
			PH_WDAT: begin
				wr_pair = 1'b1;
			end
			default: begin
				c_d.ph = PH_IDLE;
			end
		endcase
		if (wr_pair) begin
			for (int j = 0; j < 2; j++) begin
				bi = beat_pos(c_q.col[2:0], {c_q.beat, j[0]}, cfg_il);
				c_d.line[bi*DQ_W +: DQ_W] = dq_i[j*DQ_W +: DQ_W];
				c_d.wbe[bi] = !(dm_i[j] && !cfg_tdqs);
			end
			c_d.beat = c_q.beat + 2'h1;
			if (c_q.beat == c_q.last) begin
				c_d.ph = PH_IDLE;
				c_d.wr_go = 1'b1;
				if (c_q.ap)
					c_d.open[c_q.bank] = 1'b0;
			end
		end
		case (c_q.pwr)
			PW_ACTIVE: begin
				if (!cke) begin
					if (!cs_n && cmd == CMD_REF && c_q.open == '0)
						c_d.pwr = PW_SELF;
					else
						c_d.pwr = PW_DOWN;
				end else if (!cs_n) begin
					case (cmd)
						CMD_ACT: begin
							if (c_q.open[ba]) begin
								ill = 1'b1;
							end else begin
								c_d.open[ba] = 1'b1;
								c_d.row[ba] = a;
							end
						end
						CMD_PRE: begin
							if (a[PIN_AP])
								c_d.open = '0;
							else
								c_d.open[ba] = 1'b0;
						end
						CMD_RD, CMD_WR: begin
							if (!c_q.open[ba] || c_q.ph != PH_IDLE || !cfg_dll) begin
								ill = 1'b1;
							end else begin
								c_d.bank = ba;
								c_d.col = a[COL_W-1:0];
								c_d.ap = a[PIN_AP];
								c_d.cnt = 8'h01;
								c_d.beat = '0;
								c_d.wbe = '0;
								c_d.last = chop ? LAST_BC4 : LAST_BL8;
								if (cmd == CMD_RD) begin
									c_d.ph = PH_RLAT;
									m_rd = 1'b1;
									m_raddr = mk_addr(ba, c_q.row[ba], a[COL_W-1:0]);
									rd_ok = 1'b1;
								end else begin
									c_d.ph = PH_WLAT;
								end
							end
						end
						CMD_REF: begin
							if (c_q.open != '0)
								ill = 1'b1;
						end
						default: begin
						end
					endcase
				end
			end
			PW_DOWN, PW_SELF: begin
				if (cke)
					c_d.pwr = PW_ACTIVE;
			end
			default: begin
				c_d.pwr = PW_ACTIVE;
			end
		endcase
		if (ill)
			c_d.ill_tgl = ~c_q.ill_tgl;
	end

	always_ff @(posedge clk_link or negedge resetn) begin
		if (!resetn) begin
			c_q <= '0;
			c_q.pwr <= PW_ACTIVE;
			c_q.ph <= PH_IDLE;
			c_q.dq_oe_n <= 1'b1;
			c_q.dqs_oe_n <= 1'b1;
		end else begin
			c_q <= c_d;
		end
	end

	// ---------------------------------------------------------------
	// System side status
	// ---------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.pwr = stat[2:0];
		s_d.open = stat[BANKS+2:3];
		s_d.tgl = stat[SYNC_W-1];
		s_d.ill = stat[SYNC_W-1] != s_q.tgl;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign dq_o = c_q.dq;
	assign dq_oe_n = c_q.dq_oe_n;
	assign dqs_o = c_q.dqs;
	assign dqs_oe_n = c_q.dqs_oe_n;
	assign tdqs_o = c_q.tdqs;
	assign bank_open = s_q.open;
	assign power_state = s_q.pwr;
	assign illegal_cmd = s_q.ill;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	localparam int L_PRE = CL;
	localparam int L_DAT = CL + 1;
	localparam int L_APR = CL + 4;

	sequence s_preamble;
		!dqs_oe_n && dqs_o == DQS_PRE && dq_oe_n;
	endsequence

	sequence s_beat;
		!dq_oe_n && !dqs_oe_n && dqs_o == DQS_BEAT;
	endsequence

	property p_cs_ignore;
		@(posedge clk_link) disable iff (!resetn)
		(c_q.pwr == PW_ACTIVE && cke && cs_n && c_q.ph == PH_IDLE)
			|=> (c_q.open == $past(c_q.open));
	endproperty
	a_cs_ignore: assert property (p_cs_ignore)
		else $error("Bank state changed with chip select high");

	property p_act_open;
		@(posedge clk_link) disable iff (!resetn)
		(c_q.pwr == PW_ACTIVE && cke && !cs_n && cmd == CMD_ACT
			&& !c_q.open[ba])
			|=> c_q.open[$past(ba)] && c_q.row[$past(ba)] == $past(a);
	endproperty
	a_act_open: assert property (p_act_open)
		else $error("Activate did not open sampled bank and row");

	property p_pre_all;
		@(posedge clk_link) disable iff (!resetn)
		(c_q.pwr == PW_ACTIVE && cke && !cs_n && cmd == CMD_PRE
			&& a[PIN_AP]) |=> c_q.open == '0;
	endproperty
	a_pre_all: assert property (p_pre_all)
		else $error("Precharge all left a bank open");

	property p_closed_bank;
		@(posedge clk_link) disable iff (!resetn)
		(c_q.pwr == PW_ACTIVE && cke && !cs_n && c_q.ph == PH_IDLE
			&& (cmd == CMD_RD || cmd == CMD_WR) && !c_q.open[ba])
			|=> c_q.ph == PH_IDLE;
	endproperty
	a_closed_bank: assert property (p_closed_bank)
		else $error("Access to closed bank started a burst");

	property p_rd_strobe;
		@(posedge clk_link) disable iff (!resetn)
		rd_ok |-> ##L_PRE s_preamble ##1 s_beat;
	endproperty
	a_rd_strobe: assert property (p_rd_strobe)
		else $error("Read preamble or first beat misplaced");

	property p_rd_bl8;
		@(posedge clk_link) disable iff (!resetn)
		rd_ok && !chop |-> ##L_DAT s_beat [*4] ##1 dq_oe_n;
	endproperty
	a_rd_bl8: assert property (p_rd_bl8)
		else $error("Eight-beat read not four clocks long");

	property p_rd_bc4;
		@(posedge clk_link) disable iff (!resetn)
		rd_ok && chop |-> ##L_DAT s_beat [*2] ##1 dq_oe_n;
	endproperty
	a_rd_bc4: assert property (p_rd_bc4)
		else $error("Chopped read not two clocks long");

	property p_auto_pre;
		@(posedge clk_link) disable iff (!resetn)
		rd_ok && a[PIN_AP] |-> ##[1:L_APR] !c_q.open[c_q.bank];
	endproperty
	a_auto_pre: assert property (p_auto_pre)
		else $error("Auto precharge did not close the row");

	property p_wr_first;
		@(posedge clk_link) disable iff (!resetn)
		(c_q.ph == PH_WLAT && c_q.cnt >= 8'(CWL) && dqs_rise_i)
			|=> c_q.ph == PH_WDAT && c_q.wbe != '0 || c_q.tdqs == 1'b0
			&& c_q.ph == PH_WDAT;
	endproperty
	a_wr_first: assert property (p_wr_first)
		else $error("First strobe rise did not capture write data");

	property p_self_ref;
		@(posedge clk_link) disable iff (!resetn)
		(c_q.pwr == PW_ACTIVE && !cke && !cs_n && cmd == CMD_REF
			&& c_q.open == '0) |=> c_q.pwr == PW_SELF;
	endproperty
	a_self_ref: assert property (p_self_ref)
		else $error("Self-refresh entry not taken");

endmodule : dsc_core
`default_nettype wire

// ===== hdl/dsc_mem.sv
`timescale 1ns/100ps
`default_nettype none
module dsc_mem #(
	parameter int AW = 12,
	parameter int DW = 8
) (
	input wire logic clk,
	input wire logic rd,
	input wire logic [AW-1:0] raddr,
	output logic [8*DW-1:0] rdata_q,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [8*DW-1:0] wdata,
	input wire logic [7:0] wbe
);

	logic [8*DW-1:0] mem [2**AW];

	// Prefetch line store, one enable per beat
	always_ff @(posedge clk) begin
		if (rd)
			rdata_q <= mem[raddr];
		for (int i = 0; i < 8; i++) begin
			if (we && wbe[i])
				mem[waddr][i*DW +: DW] <= wdata[i*DW +: DW];
		end
	end

endmodule : dsc_mem
`default_nettype wire

// ===== hdl/dsc_pkg.sv
package dsc_pkg;

	// ---------------------------------------------------------------
	// Array geometry
	// ---------------------------------------------------------------
	localparam int BANKS = 8;
	localparam int BANK_W = 3;
	localparam int PREFETCH = 8;
	localparam int COL_W = 10;
	localparam int ROW_W_X8 = 15;
	localparam int ROW_W_X16 = 14;
	localparam int PIN_AP = 10;
	localparam int PIN_BC = 12;

	// ---------------------------------------------------------------
	// Timing counts, link clock cycles
	// ---------------------------------------------------------------
	localparam int CL_DEF = 6;
	localparam int CWL_DEF = 5;
	localparam int WR_SLACK = 2;

	// ---------------------------------------------------------------
	// Command codes {ras_n, cas_n, we_n}
	// ---------------------------------------------------------------
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_REF = 3'h1;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_WR = 3'h4;
	localparam logic [2:0] CMD_RD = 3'h5;

	// ---------------------------------------------------------------
	// Burst configuration and strobe patterns
	// ---------------------------------------------------------------
	localparam logic [1:0] BM_FIX8 = 2'h0;
	localparam logic [1:0] BM_OTF = 2'h1;
	localparam logic [1:0] BM_FIX4 = 2'h2;
	localparam logic [1:0] LAST_BL8 = 2'h3;
	localparam logic [1:0] LAST_BC4 = 2'h1;
	localparam logic [1:0] DQS_PRE = 2'h0;
	localparam logic [1:0] DQS_BEAT = 2'h2;

	typedef enum logic [4:0] {
		PH_IDLE = 5'h01,
		PH_RLAT = 5'h02,
		PH_RDAT = 5'h04,
		PH_WLAT = 5'h08,
		PH_WDAT = 5'h10
	} dsc_phase_type;

	typedef enum logic [2:0] {
		PW_ACTIVE = 3'h1,
		PW_DOWN = 3'h2,
		PW_SELF = 3'h4
	} dsc_power_type;

	// Slot of burst beat i for a given start column
	function automatic logic [2:0] beat_pos(input logic [2:0] start,
		input logic [2:0] i, input logic il);
		if (il)
			return start ^ i;
		return {start[2] ^ i[2], 2'(start[1:0] + i[1:0])};
	endfunction : beat_pos

endpackage : dsc_pkg

// ===== hdl/dsc_sync3.sv
`timescale 1ns/100ps
`default_nettype none
module dsc_sync3 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} dsc_sync_type;

	dsc_sync_type st_q;
	dsc_sync_type st_d;

	// Bit changes only once stages two and three agree
	always_comb begin
		st_d = st_q;
		st_d.s1 = d;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		st_d.q = (st_q.s2 & st_q.s3) | (st_q.q & (st_q.s2 | st_q.s3));
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign q = st_q.q;

endmodule : dsc_sync3
`default_nettype wire

// ===== verification/dsc_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none
module dsc_ctl_model import dsc_pkg::*; (
	input wire logic clk_link,
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [BANK_W-1:0] ba,
	output logic [14:0] a,
	output logic [15:0] dq_i,
	output logic dqs_rise_i
);
	initial begin
		cke = 1'b1;
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = 3'h7;
		ba = '0;
		a = '0;
		dq_i = '0;
		dqs_rise_i = 1'b0;
	end

	// One CK of command, then deselect with released lines inverted
	task automatic cmd(input logic [2:0] c, input logic [2:0] b,
		input logic [14:0] adr, input logic csn);
		@(posedge clk_link);
		#1;
		cs_n = csn;
		{ras_n, cas_n, we_n} = c;
		ba = b;
		a = adr;
		@(posedge clk_link);
		#1;
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = 3'h7;
		ba = ~b;
		a = ~adr;
	endtask : cmd

	// CKE change; with sr, a refresh rides on the same edge
	task automatic pwr(input logic ce, input logic sr);
		@(posedge clk_link);
		#1;
		cke = ce;
		cs_n = !sr;
		{ras_n, cas_n, we_n} = sr ? CMD_REF : 3'h7;
		@(posedge clk_link);
		#1;
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = 3'h7;
	endtask : pwr

	// Eight-beat write; strobe may come dly cycles late
	task automatic wr(input logic [2:0] b, input logic [14:0] adr,
		input logic [63:0] d, input int dly);
		cmd(CMD_WR, b, adr, 1'b0);
		repeat (4 + dly) @(posedge clk_link);
		for (int i = 0; i < 4; i++) begin
			#1;
			dqs_rise_i = 1'b1;
			dq_i = d[16*i +: 16];
			@(posedge clk_link);
		end
		#1;
		dqs_rise_i = 1'b0;
		dq_i = ~dq_i;
	endtask : wr
endmodule : dsc_ctl_model
`default_nettype wire

// ===== verification/test_ddr_sdram_core_access.sv
`timescale 1ns/100ps
`default_nettype none
module test_ddr_sdram_core_access import dsc_pkg::*;;
	typedef struct packed {
		logic [1:0] bm;
		logic [2:0] b;
		logic [9:0] col;
		logic bl8;
		logic il;
		logic ap;
		logic [63:0] d;
	} dsc_row_type;

	logic clk_sys, clk_link, resetn, burst_interleave;
	logic cke, cs_n, ras_n, cas_n, we_n, dqs_rise_i;
	logic [2:0] ba;
	logic [14:0] a;
	logic [15:0] dq_i, dq_o;
	logic dq_oe_n, dqs_oe_n, tdqs_o, illegal_cmd;
	logic [1:0] dqs_o;
	logic [7:0] bank_open;
	logic [2:0] power_state;
	logic [1:0] dm_i, burst_mode;
	logic tdqs_en, dll_en;
	int fails = 0;
	int n_tests = 0;
	int n_ill = 0;
	int cyc = 0;
	dsc_row_type rows [7];
	dsc_row_type mrow;

	// ---------------------------------------------------------------
	// Clocks and design
	// ---------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial begin
		clk_link = 1'b0;
		#1.7;
		forever #6 clk_link = ~clk_link;
	end

	dsc_core u_dut (.clk_sys(clk_sys), .resetn(resetn),
		.clk_link(clk_link), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .ba(ba), .a(a), .dq_i(dq_i),
		.dqs_rise_i(dqs_rise_i), .dm_i(dm_i), .dq_o(dq_o),
		.dq_oe_n(dq_oe_n), .dqs_o(dqs_o), .dqs_oe_n(dqs_oe_n),
		.tdqs_o(tdqs_o), .burst_mode(burst_mode),
		.burst_interleave(burst_interleave), .tdqs_en(tdqs_en),
		.dll_en(dll_en), .bank_open(bank_open),
		.power_state(power_state), .illegal_cmd(illegal_cmd));

	dsc_ctl_model u_ctl (.clk_link(clk_link), .cke(cke), .cs_n(cs_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .a(a),
		.dq_i(dq_i), .dqs_rise_i(dqs_rise_i));

	// Whole run needs about 900 clk_sys cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (illegal_cmd === 1'b1)
			n_ill++;
		if (cyc == 30000) begin
			fails++;
			stop_test();
		end
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [63:0] e,
		input logic [63:0] s);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic waitl(input int n);
		repeat (n) @(posedge clk_link);
		#1;
	endtask : waitl

	function automatic logic [2:0] bslot(input logic [2:0] s,
		input logic [2:0] i, input logic il);
		if (il)
			return s ^ i;
		return {s[2] ^ i[2], s[1:0] + i[1:0]};
	endfunction : bslot

	// Data was written from column 0, so slot k holds beat k
	task automatic rd_chk(input dsc_row_type r);
		int n;
		logic [2:0] s0, s1;
		n = r.bl8 ? 4 : 2;
		u_ctl.cmd(CMD_RD, r.b, {2'b00, r.bl8 ^ (r.bm != BM_OTF), 1'b0,
			r.ap, r.col}, 1'b0);
		for (int k = 1; k <= CL_DEF + n; k++) begin
			@(posedge clk_link);
			#1;
			s0 = bslot(r.col[2:0], 3'(2 * (k - CL_DEF)), r.il);
			s1 = bslot(r.col[2:0], 3'(2 * (k - CL_DEF) + 1), r.il);
			if (k == CL_DEF - 1)
				chk("read preamble", {1'b0, DQS_PRE},
					{dqs_oe_n, dqs_o});
			else if (k >= CL_DEF && k < CL_DEF + n)
				chk("read beats", {2'b00, DQS_BEAT, r.d[8*s1 +: 8],
					r.d[8*s0 +: 8]}, {dq_oe_n, dqs_oe_n, dqs_o,
					dq_o});
			else if (k == CL_DEF + n)
				chk("read release", 2'b11,
					{dq_oe_n, dqs_oe_n});
		end
	endtask : rd_chk

	// ---------------------------------------------------------------
	// Sequence
	// ---------------------------------------------------------------
	initial begin
		resetn = 1'b0;
		burst_interleave = 1'b0;
		burst_mode = BM_OTF;
		tdqs_en = 1'b0;
		dll_en = 1'b1;
		dm_i = 2'b00;
		rows = '{
			'{BM_OTF, 3'h0, 10'h000, 1'b1, 1'b0, 1'b0,
				64'h0123_4567_89ab_cdef},
			'{BM_OTF, 3'h3, 10'h005, 1'b1, 1'b0, 1'b1,
				64'hf00d_1234_5a5a_c3c3},
			'{BM_OTF, 3'h7, 10'h006, 1'b0, 1'b0, 1'b0,
				64'h8899_aabb_ccdd_eeff},
			'{BM_OTF, 3'h5, 10'h003, 1'b1, 1'b1, 1'b0,
				64'h1122_3344_5566_7788},
			'{BM_OTF, 3'h1, 10'h002, 1'b0, 1'b1, 1'b1,
				64'h0f1e_2d3c_4b5a_6978},
			'{BM_FIX8, 3'h6, 10'h004, 1'b1, 1'b0, 1'b0,
				64'h3c4b_5a69_7887_96a5},
			'{BM_FIX4, 3'h2, 10'h001, 1'b0, 1'b0, 1'b1,
				64'h7e6d_5c4b_3a29_1807}};
		repeat (2) @(posedge clk_link);
		#1;
		resetn = 1'b1;
		chk("reset outputs", 11'h600,
			{dq_oe_n, dqs_oe_n, tdqs_o, bank_open});
		waitl(8);
		chk("power after reset", PW_ACTIVE, power_state);
		foreach (rows[i]) begin
			burst_interleave = rows[i].il;
			burst_mode = rows[i].bm;
			waitl(4);
			u_ctl.cmd(CMD_ACT, rows[i].b, 15'(i), 1'b0);
			waitl(6);
			chk("bank open", 8'h01 << rows[i].b, bank_open);
			u_ctl.wr(rows[i].b, 15'h1000, rows[i].d, i % 3);
			waitl(2);
			rd_chk(rows[i]);
			waitl(8);
			chk("row after burst", rows[i].ap ? 8'h00 :
				8'h01 << rows[i].b, bank_open);
			u_ctl.cmd(CMD_PRE, rows[i].b, 15'h0000, 1'b0);
			waitl(6);
		end
		burst_mode = BM_OTF;
		burst_interleave = 1'b0;
		u_ctl.cmd(CMD_ACT, 3'h6, 15'h0000, 1'b1);
		waitl(6);
		chk("deselected activate", 8'h00, bank_open);
		u_ctl.cmd(CMD_RD, 3'h6, 15'h1000, 1'b0);
		waitl(12);
		chk("closed bank read", 1, n_ill);
		u_ctl.cmd(CMD_ACT, 3'h2, 15'h0001, 1'b0);
		u_ctl.cmd(CMD_ACT, 3'h4, 15'h0002, 1'b0);
		waitl(6);
		chk("two banks open", 8'h14, bank_open);
		u_ctl.cmd(CMD_PRE, 3'h2, 15'h0000, 1'b0);
		waitl(6);
		chk("single precharge", 8'h10, bank_open);
		u_ctl.wr(3'h4, 15'h1000, 64'hdead_beef_0bad_cafe, 4);
		waitl(12);
		chk("late strobe dropped", 2, n_ill);
		u_ctl.cmd(CMD_ACT, 3'h7, 15'h0003, 1'b0);
		u_ctl.cmd(CMD_PRE, 3'h0, 15'h0400, 1'b0);
		waitl(6);
		chk("precharge all", 8'h00, bank_open);
		dm_i = 2'b11;
		u_ctl.cmd(CMD_ACT, 3'h0, 15'h0000, 1'b0);
		waitl(6);
		u_ctl.wr(3'h0, 15'h1000, 64'hdead_beef_0bad_cafe, 0);
		waitl(2);
		rd_chk(rows[0]);
		tdqs_en = 1'b1;
		waitl(8);
		chk("termination strobe", 1'b1, tdqs_o);
		u_ctl.wr(3'h0, 15'h1000, 64'hdead_beef_0bad_cafe, 0);
		waitl(2);
		mrow = rows[0];
		mrow.d = 64'hdead_beef_0bad_cafe;
		rd_chk(mrow);
		dll_en = 1'b0;
		waitl(8);
		u_ctl.cmd(CMD_RD, 3'h0, 15'h1000, 1'b0);
		waitl(12);
		chk("read without DLL", 3, n_ill);
		dll_en = 1'b1;
		tdqs_en = 1'b0;
		dm_i = 2'b00;
		u_ctl.cmd(CMD_PRE, 3'h0, 15'h0400, 1'b0);
		u_ctl.cmd(CMD_REF, 3'h0, 15'h0000, 1'b0);
		u_ctl.cmd(CMD_REF, 3'h0, 15'h0000, 1'b0);
		waitl(12);
		chk("refresh when idle", 3, n_ill);
		u_ctl.pwr(1'b0, 1'b0);
		waitl(6);
		chk("power-down", PW_DOWN, power_state);
		u_ctl.pwr(1'b1, 1'b0);
		waitl(6);
		chk("power-up", PW_ACTIVE, power_state);
		u_ctl.pwr(1'b0, 1'b1);
		waitl(6);
		chk("self refresh", PW_SELF, power_state);
		u_ctl.pwr(1'b1, 1'b0);
		waitl(6);
		chk("self refresh exit", PW_ACTIVE, power_state);
		stop_test();
	end
endmodule : test_ddr_sdram_core_access
`default_nettype wire
